// ===== rtl/low_power_mode_pkg.sv
`default_nettype none
package low_power_mode_pkg;

    // ==========================================
    // Register offsets
    localparam logic [1:0] ADDR_SYS_CTRL2 = 2'h0;
    localparam logic [1:0] ADDR_FLASH_CTRL = 2'h1;
    localparam logic [1:0] ADDR_TB_CTRL = 2'h2;
    localparam logic [1:0] ADDR_STATUS = 2'h3;

    // ==========================================
    // Field positions
    localparam int SYS2_FAST_OSC_BIT = 7;
    localparam int SYS2_SLOW_OSC_BIT = 6;
    localparam int SYS2_CLK_SEL_BIT = 5;
    localparam int SYS2_GATE_REQ_BIT = 4;
    localparam int SYS2_HALT_REQ_BIT = 3;
    localparam int FLASH_PD_AUTO_BIT = 0;
    localparam int TB_RUN_BIT = 3;
    localparam int TB_SEL_LSB = 0;
    localparam int TB_SEL_MSB = 2;
    localparam int STAT_MODE_LSB = 5;
    localparam int STAT_WAIT_BIT = 4;
    localparam int STAT_SLOW_BIT = 3;

    // ==========================================
    // Reset values
    localparam logic RST_FAST_OSC = 1'b1;
    localparam logic RST_SLOW_OSC = 1'b0;
    localparam logic RST_CLK_SEL = 1'b0;
    localparam logic RST_FLASH_PD_AUTO = 1'b0;
    localparam logic RST_TB_RUN = 1'b0;
    localparam logic [2:0] RST_TB_SEL = 3'h0;

    // ==========================================
    // Timing counts, in periods of the halted clock
    localparam logic [10:0] WAIT_FAST_PERIODS = 11'h400;
    localparam logic [10:0] WAIT_SLOW_PERIODS = 11'h008;

    // ==========================================
    // Modes and states
    typedef enum logic [2:0] {
        MODE_FAST_SINGLE,
        MODE_FAST_DUAL,
        MODE_LOW_CLOCK_ONLY,
        MODE_CPU_HALT_FAST,
        MODE_CPU_HALT_SLOW,
        MODE_TB_HALT_FAST,
        MODE_TB_HALT_SLOW
    } mode_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_CPU_HALT,
        ST_TB_HALT,
        ST_WAIT
    } state_t;

endpackage
`default_nettype wire

// ===== rtl/low_power_mode_controller.sv
`default_nettype none
module low_power_mode_controller (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_fast_clk,
    input wire logic i_slow_clk,
    input wire logic [7:0] i_tb_src,
    input wire logic i_wake_any,
    input wire logic i_master_irq_enable,
    input wire logic i_timebase_irq_enable,
    input wire logic i_wdt_irq,
    output logic o_sys_clk,
    output logic o_fast_osc_en,
    output logic o_slow_osc_en,
    output logic o_cpu_stop,
    output logic o_wdt_stop,
    output logic o_periph_clk_en,
    output logic o_tbt_clk_en,
    output logic o_retain,
    output logic o_pc_hold,
    output logic o_irq_accept_en,
    output logic o_tb_latch_set,
    output logic o_tb_service,
    output var low_power_mode_pkg::mode_t o_mode
);

    // ==========================================
    // Declarations
    low_power_mode_pkg::state_t state_q;
    low_power_mode_pkg::mode_t mode_d;
    low_power_mode_pkg::mode_t mode_q;
    logic fast_osc_en_q;
    logic slow_osc_en_q;
    logic sys_clk_sel_q;
    logic cpu_halt_req_q;
    logic clk_gate_req_q;
    logic flash_pd_auto_q;
    logic tb_run_q;
    logic [2:0] tb_clk_sel_q;
    logic halt_slow_q;
    logic halt_auto_q;
    logic [10:0] wait_cnt_q;
    logic tb_svc_pend_q;
    logic tb_svc_q;
    logic tb_set_q;
    logic fast_prev_q;
    logic slow_prev_q;
    logic tb_prev_q;
    logic cur_slow_q;
    logic sys_clk_q;
    logic [7:0] rdata_q;
    logic wr_sys2;
    logic halt_entry;
    logic gate_entry;
    logic tb_level;
    logic tb_fall;
    logic fast_rise;
    logic slow_rise;
    logic wait_tick;
    logic cpu_release;
    logic tb_release;
    logic release_any;
    logic tb_and;

    // ==========================================
    // Bus decode and mode entry
    assign wr_sys2 = i_wr && (i_addr == low_power_mode_pkg::ADDR_SYS_CTRL2);
    assign halt_entry = wr_sys2 && (state_q == low_power_mode_pkg::ST_RUN)
        && i_wdata[low_power_mode_pkg::SYS2_HALT_REQ_BIT]
        && !i_wdt_irq;
    assign gate_entry = wr_sys2 && (state_q == low_power_mode_pkg::ST_RUN)
        && i_wdata[low_power_mode_pkg::SYS2_GATE_REQ_BIT]
        && !i_wdata[low_power_mode_pkg::SYS2_HALT_REQ_BIT]
        && !i_wdt_irq;

    // ==========================================
    // Timebase edge
    assign tb_level = i_tb_src[tb_clk_sel_q];
    assign tb_fall = tb_prev_q && !tb_level;

    // ==========================================
    // Wait clock ticks
    assign fast_rise = i_fast_clk && !fast_prev_q;
    assign slow_rise = i_slow_clk && !slow_prev_q;
    assign wait_tick = halt_slow_q ? slow_rise : fast_rise;

    // ==========================================
    // Halt release
    assign cpu_release = (state_q == low_power_mode_pkg::ST_CPU_HALT)
        && i_wake_any;
    assign tb_release = (state_q == low_power_mode_pkg::ST_TB_HALT)
        && tb_fall;
    assign release_any = cpu_release || tb_release;
    assign tb_and = i_master_irq_enable && i_timebase_irq_enable
        && tb_run_q;

    // ==========================================
    // Edge history of sampled clocks
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            fast_prev_q <= 1'b0;
            slow_prev_q <= 1'b0;
            tb_prev_q <= 1'b0;
        end else begin
            fast_prev_q <= i_fast_clk;
            slow_prev_q <= i_slow_clk;
            tb_prev_q <= tb_level;
        end
    end

    // ==========================================
    // Control registers
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            fast_osc_en_q <= low_power_mode_pkg::RST_FAST_OSC;
            slow_osc_en_q <= low_power_mode_pkg::RST_SLOW_OSC;
            sys_clk_sel_q <= low_power_mode_pkg::RST_CLK_SEL;
        end else if (wr_sys2) begin
            fast_osc_en_q <= i_wdata[low_power_mode_pkg::SYS2_FAST_OSC_BIT];
            slow_osc_en_q <= i_wdata[low_power_mode_pkg::SYS2_SLOW_OSC_BIT];
            sys_clk_sel_q <= i_wdata[low_power_mode_pkg::SYS2_CLK_SEL_BIT];
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cpu_halt_req_q <= 1'b0;
        end else if (halt_entry) begin
            cpu_halt_req_q <= 1'b1;
        end else if (cpu_release) begin
            cpu_halt_req_q <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            clk_gate_req_q <= 1'b0;
        end else if (gate_entry) begin
            clk_gate_req_q <= 1'b1;
        end else if (tb_release) begin
            clk_gate_req_q <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            flash_pd_auto_q <= low_power_mode_pkg::RST_FLASH_PD_AUTO;
        end else if (i_wr && (i_addr == low_power_mode_pkg::ADDR_FLASH_CTRL))
        begin
            flash_pd_auto_q <= i_wdata[low_power_mode_pkg::FLASH_PD_AUTO_BIT];
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            tb_run_q <= low_power_mode_pkg::RST_TB_RUN;
            tb_clk_sel_q <= low_power_mode_pkg::RST_TB_SEL;
        end else if (i_wr
            && (i_addr == low_power_mode_pkg::ADDR_TB_CTRL)) begin
            tb_run_q <= i_wdata[low_power_mode_pkg::TB_RUN_BIT];
            tb_clk_sel_q <= i_wdata[low_power_mode_pkg::TB_SEL_MSB:
                low_power_mode_pkg::TB_SEL_LSB];
        end
    end

    // ==========================================
    // Mode sequencer
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= low_power_mode_pkg::ST_RUN;
            halt_slow_q <= 1'b0;
            halt_auto_q <= 1'b0;
            wait_cnt_q <= 11'h000;
        end else begin
            case (state_q)
                low_power_mode_pkg::ST_RUN: begin
                    if (halt_entry || gate_entry) begin
                        halt_slow_q <= cur_slow_q;
                        halt_auto_q <= flash_pd_auto_q;
                        state_q <= halt_entry
                            ? low_power_mode_pkg::ST_CPU_HALT
                            : low_power_mode_pkg::ST_TB_HALT;
                    end
                end
                low_power_mode_pkg::ST_CPU_HALT,
                low_power_mode_pkg::ST_TB_HALT: begin
                    if (release_any) begin
                        if (halt_auto_q) begin
                            state_q <= low_power_mode_pkg::ST_RUN;
                        end else begin
                            state_q <= low_power_mode_pkg::ST_WAIT;
                            wait_cnt_q <= halt_slow_q
                                ? low_power_mode_pkg::WAIT_SLOW_PERIODS
                                : low_power_mode_pkg::WAIT_FAST_PERIODS;
                        end
                    end
                end
                low_power_mode_pkg::ST_WAIT: begin
                    if (wait_tick) begin
                        if (wait_cnt_q == 11'h001) begin
                            state_q <= low_power_mode_pkg::ST_RUN;
                        end
                        wait_cnt_q <= wait_cnt_q - 11'h001;
                    end
                end
                default: begin
                    state_q <= low_power_mode_pkg::ST_RUN;
                end
            endcase
        end
    end

    // ==========================================
    // Timebase latch and service
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            tb_set_q <= 1'b0;
        end else begin
            tb_set_q <= gate_entry && tb_run_q;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            tb_svc_pend_q <= 1'b0;
            tb_svc_q <= 1'b0;
        end else begin
            tb_svc_q <= 1'b0;
            if (tb_release && tb_and) begin
                tb_svc_pend_q <= 1'b1;
            end else if (tb_svc_pend_q
                && (state_q == low_power_mode_pkg::ST_RUN)) begin
                tb_svc_pend_q <= 1'b0;
                tb_svc_q <= 1'b1;
            end
        end
    end

    // ==========================================
    // Glitch-free system clock switch
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cur_slow_q <= 1'b0;
            sys_clk_q <= 1'b0;
        end else begin
            if ((sys_clk_sel_q != cur_slow_q) && !sys_clk_q
                && !i_fast_clk && !i_slow_clk) begin
                cur_slow_q <= sys_clk_sel_q;
                sys_clk_q <= 1'b0;
            end else begin
                sys_clk_q <= cur_slow_q ? i_slow_clk : i_fast_clk;
            end
        end
    end

    // ==========================================
    // Mode report
    always_comb begin
        mode_d = low_power_mode_pkg::MODE_FAST_SINGLE;
        case (state_q)
            low_power_mode_pkg::ST_CPU_HALT: begin
                mode_d = halt_slow_q
                    ? low_power_mode_pkg::MODE_CPU_HALT_SLOW
                    : low_power_mode_pkg::MODE_CPU_HALT_FAST;
            end
            low_power_mode_pkg::ST_TB_HALT: begin
                mode_d = halt_slow_q
                    ? low_power_mode_pkg::MODE_TB_HALT_SLOW
                    : low_power_mode_pkg::MODE_TB_HALT_FAST;
            end
            default: begin
                if (cur_slow_q) begin
                    mode_d = low_power_mode_pkg::MODE_LOW_CLOCK_ONLY;
                end else if (slow_osc_en_q) begin
                    mode_d = low_power_mode_pkg::MODE_FAST_DUAL;
                end else begin
                    mode_d = low_power_mode_pkg::MODE_FAST_SINGLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            mode_q <= low_power_mode_pkg::MODE_FAST_SINGLE;
        end else begin
            mode_q <= mode_d;
        end
    end

    // ==========================================
    // Register read port
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rdata_q <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                low_power_mode_pkg::ADDR_SYS_CTRL2: begin
                    rdata_q <= {fast_osc_en_q, slow_osc_en_q, sys_clk_sel_q,
                        clk_gate_req_q, cpu_halt_req_q, 3'h0};
                end
                low_power_mode_pkg::ADDR_FLASH_CTRL: begin
                    rdata_q <= {7'h00, flash_pd_auto_q};
                end
                low_power_mode_pkg::ADDR_TB_CTRL: begin
                    rdata_q <= {4'h0, tb_run_q, tb_clk_sel_q};
                end
                default: begin
                    rdata_q <= {mode_q,
                        state_q == low_power_mode_pkg::ST_WAIT,
                        cur_slow_q, 3'h0};
                end
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // ==========================================
    // Outputs
    assign o_rdata = rdata_q;
    assign o_sys_clk = sys_clk_q;
    assign o_fast_osc_en = fast_osc_en_q;
    assign o_slow_osc_en = slow_osc_en_q;

    // ==========================================
    // Halt status outputs
    assign o_cpu_stop = (state_q != low_power_mode_pkg::ST_RUN);
    assign o_wdt_stop = (state_q == low_power_mode_pkg::ST_CPU_HALT)
        || (state_q == low_power_mode_pkg::ST_TB_HALT);
    assign o_periph_clk_en =
        (state_q != low_power_mode_pkg::ST_TB_HALT);
    assign o_tbt_clk_en = 1'b1;
    assign o_retain = (state_q != low_power_mode_pkg::ST_RUN);
    assign o_pc_hold = (state_q != low_power_mode_pkg::ST_RUN);

    // ==========================================
    // Interrupt outputs
    assign o_irq_accept_en = (state_q == low_power_mode_pkg::ST_RUN)
        && i_master_irq_enable && !tb_svc_pend_q;
    assign o_tb_latch_set = tb_set_q;
    assign o_tb_service = tb_svc_q;
    assign o_mode = mode_q;

endmodule
`default_nettype wire

// ===== bench/lpm_checker_assertions.sv
`default_nettype none
module lpm_checker (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic [7:0] i_tb_src,
    input wire logic i_wake_any,
    input wire logic i_master_irq_enable,
    input wire logic i_timebase_irq_enable,
    input wire logic i_wdt_irq,
    input wire logic o_cpu_stop,
    input wire logic o_wdt_stop,
    input wire logic o_periph_clk_en,
    input wire logic o_tbt_clk_en,
    input wire logic o_irq_accept_en,
    input wire logic o_tb_latch_set,
    input wire logic o_tb_service
);
    timeunit 1ns;
    timeprecision 1ps;
    logic auto_q;
    logic run_q;
    logic [2:0] sel_q;
    logic [12:0] wcnt_q;
    logic ok;
    logic gate;
    logic fall;
    // ==========================================
    // Shadow of software settings
    assign ok = i_wr && i_addr == 2'h0 && !o_cpu_stop && !i_wdt_irq;
    assign gate = ok && i_wdata[4] && !i_wdata[3];
    assign fall = o_cpu_stop && !o_periph_clk_en && auto_q && !i_tb_src[sel_q];
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            auto_q <= 1'b0;
            run_q <= 1'b0;
            sel_q <= 3'h0;
        end else if (i_wr && i_addr == 2'h1) begin
            auto_q <= i_wdata[0];
        end else if (i_wr && i_addr == 2'h2) begin
            run_q <= i_wdata[3];
            sel_q <= i_wdata[2:0];
        end
    end
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            wcnt_q <= 13'h0000;
        end else begin
            wcnt_q <= (o_cpu_stop && !o_wdt_stop) ? wcnt_q + 13'h0001
                : 13'h0000;
        end
    end
    // ==========================================
    // Properties
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    a_halt_enter: assert property (
        ok && i_wdata[3] |-> ##1 o_cpu_stop && o_wdt_stop && o_periph_clk_en)
        else $error("cpu halt not entered");
    a_wdt_blocks: assert property (
        i_wr && i_addr == 2'h0 && !o_cpu_stop && i_wdt_irq && |i_wdata[4:3]
        |-> ##1 !o_cpu_stop) else $error("halt entered over watchdog");
    a_gate_enter: assert property (
        gate |-> ##1 o_cpu_stop && !o_periph_clk_en && o_tbt_clk_en)
        else $error("timebase halt not entered");
    a_tb_latch: assert property (
        gate |-> ##1 o_tb_latch_set == run_q ##1 !o_tb_latch_set)
        else $error("timebase latch pulse wrong");
    a_wake_release: assert property (
        o_cpu_stop && o_wdt_stop && o_periph_clk_en && i_wake_any && auto_q
        |-> ##1 !o_cpu_stop) else $error("cpu halt not released");
    a_no_irq_stop: assert property (
        o_cpu_stop |-> !o_irq_accept_en)
        else $error("irq taken while stopped");
    a_wait_bound: assert property (
        wcnt_q <= 13'd4110) else $error("flash wait too long");
    a_tb_release: assert property (
        fall && $past(i_tb_src[sel_q]) |-> ##1 !o_cpu_stop)
        else $error("timebase halt not released");
    a_tb_service: assert property (
        fall && $past(i_tb_src[sel_q]) |-> ##2 o_tb_service ==
        $past(i_master_irq_enable && i_timebase_irq_enable && run_q, 2))
        else $error("timebase service pulse wrong");
endmodule
bind low_power_mode_controller lpm_checker u_chk (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_tb_src(i_tb_src), .i_wake_any(i_wake_any),
    .i_master_irq_enable(i_master_irq_enable), .i_wdt_irq(i_wdt_irq),
    .i_timebase_irq_enable(i_timebase_irq_enable), .o_cpu_stop(o_cpu_stop),
    .o_wdt_stop(o_wdt_stop), .o_periph_clk_en(o_periph_clk_en),
    .o_tbt_clk_en(o_tbt_clk_en), .o_irq_accept_en(o_irq_accept_en),
    .o_tb_latch_set(o_tb_latch_set), .o_tb_service(o_tb_service)
);
`default_nettype wire

// ===== bench/lpm_far_side.sv
`default_nettype none
module lpm_far_side (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_fast_en,
    input wire logic i_slow_en,
    input wire logic i_irq_set,
    input wire logic i_irq_clr,
    output logic o_fast_clk,
    output logic o_slow_clk,
    output logic [7:0] o_tb_src,
    output logic o_wake_any
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] div_q;
    logic irq_q;
    // ==========================================
    // Oscillators stop when disabled
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            div_q <= 11'h000;
        end else begin
            div_q <= div_q + 11'h001;
        end
    end
    assign o_fast_clk = div_q[1] && i_fast_en;
    assign o_slow_clk = div_q[3] && i_slow_en;
    assign o_tb_src = div_q[10:3];
    // ==========================================
    // Source latch held until cleared
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            irq_q <= 1'b0;
        end else if (i_irq_clr) begin
            irq_q <= 1'b0;
        end else if (i_irq_set) begin
            irq_q <= 1'b1;
        end
    end
    assign o_wake_any = irq_q;
endmodule
`default_nettype wire

// ===== bench/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic [1:0] i_addr = 2'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic master_irq_enable = 1'b0;
    logic tben = 1'b0;
    logic wdt = 1'b0;
    logic iset = 1'b0;
    logic iclr = 1'b0;
    logic fclk, sclk, wake, fen, sen, stop, wstop, pen, ten, ret, pch, acc;
    logic lset, svc, svc_seen, sysc;
    logic sys_p = 1'b0;
    int sys_len = 2;
    logic [7:0] tbs, rdata;
    low_power_mode_pkg::mode_t mode;
    int num_errors = 0;
    int cmp_count = 0;
    always #5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) if (svc === 1'b1) svc_seen = 1'b1;
    low_power_mode_controller u_dut (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_fast_clk(fclk),
        .i_slow_clk(sclk), .i_tb_src(tbs), .i_wake_any(wake),
        .i_master_irq_enable(master_irq_enable), .i_timebase_irq_enable(tben),
        .i_wdt_irq(wdt), .o_sys_clk(sysc), .o_fast_osc_en(fen),
        .o_slow_osc_en(sen), .o_cpu_stop(stop), .o_wdt_stop(wstop),
        .o_periph_clk_en(pen), .o_tbt_clk_en(ten), .o_retain(ret),
        .o_pc_hold(pch), .o_irq_accept_en(acc), .o_tb_latch_set(lset),
        .o_tb_service(svc), .o_mode(mode));
    lpm_far_side u_far (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_fast_en(fen), .i_slow_en(sen),
        .i_irq_set(iset), .i_irq_clr(iclr), .o_fast_clk(fclk),
        .o_slow_clk(sclk), .o_tb_src(tbs), .o_wake_any(wake));
    // ==========================================
    // Bench helpers
    function automatic logic [7:0] hmode(input logic slow);
        return {5'h0, slow ? low_power_mode_pkg::MODE_CPU_HALT_SLOW :
            low_power_mode_pkg::MODE_CPU_HALT_FAST};
    endfunction
    task automatic end_sim;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e,
        input logic [7:0] s);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e,
        input string n);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        chk(n, e, rdata);
    endtask
    task automatic irq(input logic set);
        @(posedge i_mclk);
        iset <= set;
        iclr <= !set;
        @(posedge i_mclk);
        iset <= 1'b0;
        iclr <= 1'b0;
        #1;
    endtask
    task automatic wait_run(output int n);
        n = 0;
        while (stop !== 1'b0 && n < 5000) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
    endtask
    // ==========================================
    // System clock phase monitor
    always @(posedge i_mclk) begin
        if (i_rst) begin
            sys_len <= 2;
        end else if (sysc !== sys_p) begin
            chk("sys phase", 8'h01, {7'h0, sys_len > 1});
            sys_len <= 1;
        end else begin
            sys_len <= sys_len + 1;
        end
        sys_p <= sysc;
    end
    // ==========================================
    // Scenarios
    initial begin
        int n;
        logic m;
        logic e;
        logic r;
        void'($urandom(32'h6a7635b1));
        repeat (16) @(posedge i_mclk);
        i_rst <= 1'b0;
        rd(2'h0, 8'h80, "ctrl reset");
        rd(2'h2, 8'h00, "tb reset");
        wr(2'h3, 8'hff);
        rd(2'h3, 8'h00, "status");
        wr(2'h1, 8'h01);
        for (int i = 0; i < 4; i++) begin
            m = 1'($urandom_range(1, 0));
            master_irq_enable <= m;
            wr(2'h0, 8'h88);
            chk("stop", 8'h07, {5'h0, stop, wstop, pen});
            chk("hold", 8'h03, {6'h0, ret, pch});
            repeat ($urandom_range(20, 1)) @(posedge i_mclk);
            #1;
            chk("halt mode", hmode(1'b0), {5'h0, mode});
            rd(2'h0, 8'h88, "req bit");
            irq(1'b1);
            wait_run(n);
            rd(2'h0, 8'h80, "req clear");
            chk("accept", {7'h0, m}, {7'h0, acc});
            irq(1'b0);
        end
        @(posedge i_mclk);
        wdt <= 1'b1;
        wr(2'h0, 8'h88);
        wr(2'h0, 8'h90);
        rd(2'h0, 8'h80, "wdt block");
        wdt <= 1'b0;
        wr(2'h1, 8'h00);
        wr(2'h0, 8'h88);
        irq(1'b1);
        wait_run(n);
        chk("fast wait", 8'h01, {7'h0, n >= 4090 && n <= 4110});
        irq(1'b0);
        wr(2'h0, 8'hc0);
        wr(2'h0, 8'he0);
        wr(2'h0, 8'h60);
        repeat (40) @(posedge i_mclk);
        rd(2'h3, 8'h48, "slow status");
        wr(2'h0, 8'h68);
        @(posedge i_mclk);
        #1;
        chk("slow halt", hmode(1'b1), {5'h0, mode});
        irq(1'b1);
        wait_run(n);
        chk("slow wait", 8'h01, {7'h0, n >= 100 && n <= 150});
        chk("slow back", 8'h02, {5'h0, mode});
        irq(1'b0);
        wr(2'h0, 8'he0);
        repeat (50) @(posedge i_mclk);
        wr(2'h0, 8'hc0);
        repeat (40) @(posedge i_mclk);
        rd(2'h3, 8'h20, "fast status");
        wr(2'h1, 8'h01);
        for (int i = 0; i < 6; i++) begin
            {m, e, r} = 3'($urandom);
            master_irq_enable <= m;
            tben <= e;
            wr(2'h2, {4'h0, r, 3'($urandom_range(2, 0))});
            svc_seen = 1'b0;
            wr(2'h0, 8'hd0);
            chk("gated", 8'h05, {5'h0, stop, pen, ten});
            chk("tb latch", {7'h0, r}, {7'h0, lset});
            wait_run(n);
            repeat (3) @(posedge i_mclk);
            chk("service", {7'h0, m & e & r}, {7'h0, svc_seen});
            chk("tb bound", 8'h01, {7'h0, n < 300});
            rd(2'h0, 8'hc0, "gate clear");
        end
        wr(2'h0, 8'hc8);
        @(posedge i_mclk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        #1;
        chk("reset run", 8'h00, {4'h0, stop, mode});
        rd(2'h0, 8'h80, "reset ctrl");
        end_sim;
    end
    initial begin
        repeat (60000) @(posedge i_mclk);
        num_errors++;
        end_sim;
    end
endmodule
`default_nettype wire
